// ==== common/slrp_pkg.sv ====
// Constants shared by the slow oscillator reload prescaler design files.
// Assumes one system clock aclk; the oscillator arrives as an asynchronous pin.
//
// Functional notes
// - Six-bit read/write reload field in bits 5 to 0, values 0 to 63.
// - Bits 7 and 6 of the reload register read zero; writes ignored.
// - A down counter stepped by the slow oscillator makes the divided clock.
// - Software writes the reload field on the bus clock, asynchronous to oscillator.
// - Counter takes in the reload value when its count reaches zero.
// - The divided clock pulse is emitted when the reload counter underflows.
// - The divided clock runs continuously; nothing can stop it. Here it stops while soft_rst is held high or aresetn is held low.
// - A write coinciding with a reload gives no guaranteed captured value.
// - Reading the reload field returns the value software last wrote.
// - Reload register clears on full reset only; software reset keeps it.
package slrp_pkg;
   localparam int         RELOAD_W     = 6;
   localparam int         REG_W        = 8;
   localparam logic [7:0] RELOAD_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [5:0] RELOAD_RST   = 6'h00;
   localparam int         STAT_CNT_LSB = 0;
   localparam int         STAT_LD_LSB  = 8;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   localparam int         MAX_PERIOD   = 64;
endpackage : slrp_pkg

// ==== rtl/slrp_sync_edge.sv ====
// Two-stage synchroniser with a registered rising-edge pulse.
// Assumes the input is a slow free-running clock far below aclk.
`timescale 1ns/100ps
module slrp_sync_edge (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic async_in,
   output logic      rise_pulse
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // The first stage feeds only the second; the edge is taken after it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q     <= 1'b0;
         sync_q     <= 1'b0;
         prev_q     <= 1'b0;
         rise_pulse <= 1'b0;
      end else begin
         meta_q     <= async_in;
         sync_q     <= meta_q;
         prev_q     <= sync_q;
         rise_pulse <= sync_q & ~prev_q;
      end
   end

   // One pulse per synchronised rising edge, one cycle late.
   a_edge_pulse : assert property (@(posedge aclk) disable iff (!aresetn)
      rise_pulse == $past(sync_q & ~prev_q))
      else $error("edge pulse does not follow synchronised rise");
endmodule : slrp_sync_edge

// ==== rtl/slrp_reload_counter.sv ====
// Reload down counter stepped by oscillator edge pulses.
// Assumes tick is a one-cycle pulse in the aclk domain.
`timescale 1ns/100ps
module slrp_reload_counter
   import slrp_pkg::*;
#(
   parameter int W = 6
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         soft_rst,
   input  wire logic         tick,
   input  wire logic [W-1:0] reload_value,
   output logic [W-1:0]      count_q,
   output logic [W-1:0]      loaded_q,
   output logic              underflow_q
);
   // The period check below counts to MAX_PERIOD, so wider reloads are refused.
   if (W < 1 || (2 ** W) > MAX_PERIOD) begin : g_bad_width
      $error("reload counter width must be 1 to 6");
   end

   logic at_zero;
   logic [6:0] since_q;
   assign at_zero = (count_q == '0);

   // At zero the counter takes in the reload value and flags the underflow.
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         count_q     <= '0;
         loaded_q    <= '0;
         underflow_q <= 1'b0;
      end else begin
         underflow_q <= tick & at_zero;
         if (tick && at_zero) begin
            count_q  <= reload_value;
            loaded_q <= reload_value;
         end else if (tick) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   // Ticks since the last underflow; only the checks below read it.
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         since_q <= 7'h00;
      end else if (tick && at_zero) begin
         since_q <= 7'h00;
      end else if (tick) begin
         since_q <= since_q + 7'h01;
      end
   end

   a_load_zero : assert property (@(posedge aclk) disable iff (!aresetn || soft_rst)
      tick && at_zero |=> count_q == $past(reload_value))
      else $error("counter did not take in reload at zero");
   a_count_down : assert property (@(posedge aclk) disable iff (!aresetn || soft_rst)
      tick && !at_zero |=> count_q == $past(count_q) - 1'b1)
      else $error("counter did not step down on tick");
   a_never_stop : assert property (@(posedge aclk) disable iff (!aresetn || soft_rst)
      since_q < 7'(MAX_PERIOD))
      else $error("divided clock missed its underflow");
   a_zero_rate : assert property (@(posedge aclk) disable iff (!aresetn || soft_rst)
      tick && at_zero && reload_value == '0 |=> at_zero)
      else $error("zero reload did not give undivided rate");
endmodule : slrp_reload_counter

// ==== rtl/slrp_top.sv ====
// Slow oscillator reload prescaler with its AXI4-Lite register slave.
// Assumes the slow oscillator pin is far slower than aclk and free running;
// the full reset is aresetn and the software reset arrives as soft_rst.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module slrp_top
   import slrp_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              soft_rst,
   input  wire logic              slow_osc_clk_in,
   output logic                   slow_osc_divided_clock,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
      $error("ADDR_W must be 3 to 8");
   end

   // Word index of each register at the configured address width.
   localparam logic [ADDR_W-3:0] IDX_RELOAD = RELOAD_OFS[ADDR_W-1:2];
   localparam logic [ADDR_W-3:0] IDX_STATUS = STATUS_OFS[ADDR_W-1:2];

   logic [RELOAD_W-1:0] reload_q;
   logic [RELOAD_W-1:0] reload_d;
   logic [RELOAD_W-1:0] count_q;
   logic [RELOAD_W-1:0] loaded_q;
   logic                osc_tick;
   logic                underflow;

   logic                aw_held_q;
   logic [ADDR_W-1:0]   awaddr_q;
   logic                w_held_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                rvalid_q;
   logic [31:0]         rdata_q;
   logic [1:0]          rresp_q;

   // The protection bits carry no meaning for this block.
   logic unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

   // ------------------------------------------------------------------
   // Write channel handshakes. Address and data may come in either order;
   // each is held until the other arrives, and a pending response stalls both.
   // ------------------------------------------------------------------
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs  = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_held_q | aw_hs;
   wire w_have  = w_held_q | w_hs;
   wire wr_fire = aw_have & w_have & ~bvalid_q;

   assign s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign s_axi_wready  = ~w_held_q & ~bvalid_q;

   // Effective payload of the write being committed.
   wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
   wire [31:0]       wr_data = w_held_q ? wdata_q : s_axi_wdata;
   wire [3:0]        wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

   // Write decode on the word index; the byte offset bits are ignored.
   wire [ADDR_W-3:0] wr_idx     = wr_addr[ADDR_W-1:2];
   wire              wr_reload  = wr_fire & (wr_idx == IDX_RELOAD);
   wire              wr_status  = wr_fire & (wr_idx == IDX_STATUS);
   wire              wr_mapped  = (wr_idx == IDX_RELOAD) | (wr_idx == IDX_STATUS);
   wire              reload_wen = wr_reload & wr_strb[0];

   // Only bits 5 to 0 are stored, so bits 7 and 6 of a write are dropped.
   assign reload_d = reload_wen ? wr_data[RELOAD_W-1:0] : reload_q;

   // The reload register is on the bus clock; only the full reset clears it.
   // Software reset is deliberately absent here so the division survives it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_q <= RELOAD_RST;
      end else begin
         reload_q <= reload_d;
      end
   end

   // Hold registers for a lone address or lone data beat.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end else if (aw_hs) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end else if (w_hs) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end
   end

   // Write response, one cycle after commit. The status word is read only,
   // so a write to it is accepted and ignored; other addresses get SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ------------------------------------------------------------------
   // Read channel. One read is in flight at a time; arready drops while
   // the answer waits for rready.
   // ------------------------------------------------------------------
   wire              ar_hs     = s_axi_arvalid & s_axi_arready;
   wire [ADDR_W-3:0] rd_idx    = s_axi_araddr[ADDR_W-1:2];
   wire              rd_reload = (rd_idx == IDX_RELOAD);
   wire              rd_status = (rd_idx == IDX_STATUS);

   assign s_axi_arready = ~rvalid_q;

   // Reserved bits above the field read as zero.
   wire [31:0] reload_word = {{(32 - RELOAD_W){1'b0}}, reload_q};

   // Status shows the live count and the value last taken in.
   wire [31:0] status_word =
      ({{(32 - RELOAD_W){1'b0}}, count_q} << STAT_CNT_LSB) |
      ({{(32 - RELOAD_W){1'b0}}, loaded_q} << STAT_LD_LSB);

   wire [31:0] rd_word = rd_reload ? reload_word :
                         rd_status ? status_word : 32'h0000_0000;
   wire [1:0]  rd_resp = (rd_reload | rd_status) ? RESP_OKAY : RESP_SLVERR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_resp;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // ------------------------------------------------------------------
   // Oscillator path. The pin is brought into aclk through two flops and
   // each rising edge becomes one tick; aclk must exceed twice the rate.
   // ------------------------------------------------------------------
   slrp_sync_edge u_sync (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .async_in   (slow_osc_clk_in),
      .rise_pulse (osc_tick)
   );

   // The counter samples reload_q on the tick edge itself. A write in that
   // same cycle lands one edge too late, so the old value is captured; the
   // zero-then-wait procedure avoids depending on which value wins.
   slrp_reload_counter #(
      .W (RELOAD_W)
   ) u_cnt (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .soft_rst     (soft_rst),
      .tick         (osc_tick),
      .reload_value (reload_q),
      .count_q      (count_q),
      .loaded_q     (loaded_q),
      .underflow_q  (underflow)
   );

   // The divided clock is a one-cycle pulse per underflow, with no gate.
   assign slow_osc_divided_clock = underflow;

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------
   sequence s_reload_commit;
      reload_wen;
   endsequence

   sequence s_reload_read;
      ar_hs && rd_reload && !reload_wen;
   endsequence

   a_field_store : assert property (@(posedge aclk) disable iff (!aresetn)
      s_reload_commit |=> reload_q == $past(wr_data[RELOAD_W-1:0]))
      else $error("reload field did not take written value");

   a_read_back : assert property (@(posedge aclk) disable iff (!aresetn)
      s_reload_read |=> s_axi_rvalid && s_axi_rdata[RELOAD_W-1:0] == reload_q)
      else $error("reload read does not match stored value");

   a_reserved_zero : assert property (@(posedge aclk) disable iff (!aresetn)
      s_reload_read |=> s_axi_rdata[31:RELOAD_W] == '0)
      else $error("reserved reload bits read nonzero");

   a_soft_keep : assert property (@(posedge aclk) disable iff (!aresetn)
      soft_rst && !reload_wen |=> reload_q == $past(reload_q))
      else $error("software reset disturbed reload register");

   a_no_stray_write : assert property (@(posedge aclk) disable iff (!aresetn)
      !reload_wen |=> $stable(reload_q))
      else $error("reload changed without a bus write");

   a_write_resp : assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid && s_axi_bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR))
      else $error("write response missing or wrong");

   a_read_hold : assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before rready");

   a_status_sticks : assert property (@(posedge aclk) disable iff (!aresetn)
      wr_status |=> $stable(reload_q))
      else $error("status write changed reload");

   a_underflow_out : assert property (@(posedge aclk) disable iff (!aresetn || soft_rst)
      osc_tick && count_q == '0 |=> slow_osc_divided_clock ##1 !slow_osc_divided_clock)
      else $error("underflow did not give a single output pulse");

   a_capture_old : assert property (@(posedge aclk) disable iff (!aresetn || soft_rst)
      osc_tick && count_q == '0 && reload_wen |=> loaded_q == $past(reload_q))
      else $error("coinciding write not resolved to old value");

   // ------------------------------------------------------------------
   // Bus and counter checks. A slave that drops an answer or takes a second
   // request early would hang or corrupt a master that keeps the rules.
   // ------------------------------------------------------------------
   sequence s_b_waiting;
      s_axi_bvalid && !s_axi_bready;
   endsequence

   sequence s_r_done;
      s_axi_rvalid && s_axi_rready;
   endsequence

   sequence s_status_read;
      ar_hs && rd_status;
   endsequence

   a_b_refuse : assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");

   a_r_refuse : assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");

   a_b_hold : assert property (@(posedge aclk) disable iff (!aresetn)
      s_b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");

   a_b_release : assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response outstayed its handshake");

   a_r_release : assert property (@(posedge aclk) disable iff (!aresetn)
      s_r_done |=> !s_axi_rvalid)
      else $error("read answer outstayed its handshake");

   a_read_resp : assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs |=> s_axi_rvalid && s_axi_rresp == $past(rd_resp))
      else $error("read response missing or wrong");

   a_unmapped_zero : assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && !rd_reload && !rd_status |=> s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   a_one_commit : assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> !wr_fire)
      else $error("second write committed before response");

   a_strobe_off : assert property (@(posedge aclk) disable iff (!aresetn)
      wr_reload && !wr_strb[0] |=> $stable(reload_q))
      else $error("disabled byte lane changed reload");

   a_status_count : assert property (@(posedge aclk) disable iff (!aresetn)
      s_status_read |=> s_axi_rdata[STAT_CNT_LSB +: RELOAD_W] == $past(count_q) &&
                        s_axi_rdata[STAT_LD_LSB +: RELOAD_W] == $past(loaded_q))
      else $error("status word does not show counter state");

   a_count_range : assert property (@(posedge aclk) disable iff (!aresetn)
      count_q <= loaded_q)
      else $error("count above the value last taken in");

   a_pulse_single : assert property (@(posedge aclk) disable iff (!aresetn)
      slow_osc_divided_clock |=> !slow_osc_divided_clock)
      else $error("divided clock pulse longer than one cycle");

   a_pulse_cause : assert property (@(posedge aclk) disable iff (!aresetn || soft_rst)
      slow_osc_divided_clock |-> $past(osc_tick && count_q == '0))
      else $error("divided clock pulse without underflow");

   a_soft_restart : assert property (@(posedge aclk) disable iff (!aresetn)
      soft_rst |=> count_q == '0 && loaded_q == '0 && !slow_osc_divided_clock)
      else $error("software reset did not restart counter");

   a_full_clear : assert property (@(posedge aclk)
      !aresetn |=> reload_q == RELOAD_RST && !s_axi_bvalid && !s_axi_rvalid)
      else $error("full reset did not clear the block");
endmodule : slrp_top

// ==== sim/slrp_osc_model.sv ====
// Behavioural stand-in for the slow on-chip oscillator feeding the prescaler.
// Assumes aclk is far faster than this source; its phase is unrelated to aclk.
`timescale 1ns/100ps
module slrp_osc_model #(
   parameter int FAST_HALF_NS = 365,
   parameter int SLOW_HALF_NS = 1015
) (
   input  wire logic slow_sel,
   output logic      osc_out,
   output int        edge_count
);
   // The source never pauses, so the divided output stops only while aresetn or soft_rst holds the counter in reset.
   // Rising edges are counted so the bench can measure periods in oscillator cycles.
   initial begin
      osc_out    = 1'h0;
      edge_count = 0;
      #17;
      forever begin
         #(slow_sel ? SLOW_HALF_NS : FAST_HALF_NS);
         osc_out = ~osc_out;
         if (osc_out) edge_count = edge_count + 1;
      end
   end
endmodule : slrp_osc_model

// ==== sim/testbench.sv ====
// Self-checking bench for the slow oscillator reload prescaler and its register slave.
// Assumes the oscillator model drives the pin and a bus master task plays software.
`timescale 1ns/100ps
module testbench;
   import slrp_pkg::*;
   logic        aclk, aresetn, soft_rst, slow_sel, osc, div_clk;
   logic [3:0]  awaddr, araddr, wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rnd, d;
   logic [1:0]  bresp, rresp, r;
   int          err_count, compares, edges, model_reload, e0, e1, old;
   int          vals[5];

   // The bench clock runs at 20 MHz.
   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end

   slrp_osc_model osc_i (.slow_sel(slow_sel), .osc_out(osc), .edge_count(edges));
   slrp_top #(.ADDR_W(4)) dut (
      .aclk(aclk), .aresetn(aresetn), .soft_rst(soft_rst), .slow_osc_clk_in(osc),
      .slow_osc_divided_clock(div_clk), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic hung();
      err_count++;
      $display("mismatch at %0t: no answer in time", $time);
   endtask : hung

   task automatic conclude();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude

   // Ready levels are observed mid-cycle, where they are settled, and the handshake
   // then counts at the following rising edge; signals are released only after it.
   task automatic axi_write(input logic [3:0] a, input logic [31:0] dat,
                            input logic [3:0] s, output logic [1:0] resp);
      logic aw_hs, w_hs, b_hs;
      b_hs = 1'h0;
      awaddr  <= a;
      wdata   <= dat;
      wstrb   <= s;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!b_hs) begin
         @(negedge aclk);
         aw_hs = awvalid & awready;
         w_hs  = wvalid & wready;
         b_hs  = bvalid & bready;
         resp  = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'h0;
         if (w_hs) wvalid <= 1'h0;
         if (b_hs) bready <= 1'h0;
      end
      // One idle edge, so a following call never reraises bready in this step.
      @(posedge aclk);
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, output logic [31:0] dat,
                           output logic [1:0] resp);
      logic ar_hs, r_hs;
      r_hs = 1'h0;
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!r_hs) begin
         @(negedge aclk);
         ar_hs = arvalid & arready;
         r_hs  = rvalid & rready;
         dat   = rdata;
         resp  = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'h0;
         if (r_hs) rready <= 1'h0;
      end
      // One idle edge, so a following call never reraises rready in this step.
      @(posedge aclk);
   endtask : axi_read

   // The model keeps only the low six bits of a reload write whose low byte is enabled.
   task automatic reg_write(input logic [3:0] a, input logic [31:0] dat, input logic [3:0] s);
      logic [1:0] resp;
      axi_write(a, dat, s, resp);
      if (a == RELOAD_OFS[3:0] && s[0]) model_reload = dat % 64;
      check({30'h0, resp}, (a == 4'h0 || a == 4'h4) ? RESP_OKAY : RESP_SLVERR);
   endtask : reg_write

   task automatic check_reload();
      logic [31:0] dat;
      logic [1:0]  resp;
      axi_read(RELOAD_OFS[3:0], dat, resp);
      check(dat, 32'(model_reload));
      check({30'h0, resp}, {30'h0, RESP_OKAY});
   endtask : check_reload

   // Output pulses are stamped with the oscillator edge count; each lasts one cycle.
   task automatic wait_pulse(output int e);
      int n;
      n = 0;
      e = -1;
      while (e < 0 && n < 8000) begin
         @(negedge aclk);
         if (div_clk === 1'h1) e = edges;
         n++;
      end
      @(negedge aclk);
      check({31'h0, div_clk}, 32'h0);
      if (e < 0) hung();
      @(posedge aclk);
   endtask : wait_pulse

   // Two pulses resynchronise after a change, then two whole periods are measured.
   task automatic run_check(input int k);
      int a, b;
      wait_pulse(a);
      wait_pulse(a);
      repeat (2) begin
         wait_pulse(b);
         check(32'(b - a), 32'(k + 1));
         a = b;
      end
   endtask : run_check

   // Zero first, then wait out the old count, so a reload that meets the write can only take in zero.
   task automatic change_reload(input int v, input logic [31:0] junk);
      if (model_reload != 0) begin
         reg_write(RELOAD_OFS[3:0], 32'h0, 4'hF);
         repeat (model_reload * 41 + 10) @(posedge aclk);
      end
      reg_write(RELOAD_OFS[3:0], (junk & 32'hFFFFFFC0) | 32'(v), 4'hF);
   endtask : change_reload

   // The watchdog allows about three times the expected run.
   initial begin
      repeat (60000) @(posedge aclk);
      hung();
      conclude();
   end

   // Main sequence: registers, periods, mid-period change, soft and full reset.
   initial begin
      rnd = $urandom(39629);
      {err_count, compares, model_reload} = '0;
      {aresetn, soft_rst, slow_sel, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {awaddr, araddr, wstrb, wdata} = '0;
      vals = '{1, 63, 0, 2, 0};
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      check_reload();
      axi_read(4'h8, d, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      reg_write(4'hC, 32'h5, 4'hF);
      reg_write(STATUS_OFS[3:0], 32'h3F, 4'hF);
      for (int i = 0; i < 6; i++) begin
         rnd = $urandom;
         // A real change keeps the zero-then-wait procedure; a masked lane changes nothing.
         if (rnd[31]) change_reload(int'(rnd[5:0]), rnd);
         else reg_write(RELOAD_OFS[3:0], rnd, 4'hE);
         check_reload();
      end
      vals[4] = $urandom_range(40, 8);
      for (int i = 0; i < 5; i++) begin
         slow_sel <= i[0];
         change_reload(vals[i], $urandom);
         run_check(vals[i]);
         axi_read(STATUS_OFS[3:0], d, r);
         check(d & 32'hFFFFFFC0, 32'(vals[i]) << 8);
      end
      wait_pulse(e0);
      old = model_reload;
      reg_write(RELOAD_OFS[3:0], 32'h0, 4'hF);
      wait_pulse(e1);
      check(32'(e1 - e0), 32'(old + 1));
      wait_pulse(e0);
      check(32'(e0 - e1), 32'h1);
      change_reload(6, $urandom);
      soft_rst <= 1'h1;
      repeat (3) @(posedge aclk);
      soft_rst <= 1'h0;
      @(posedge aclk);
      check_reload();
      run_check(6);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      model_reload = 0;
      @(posedge aclk);
      check_reload();
      run_check(0);
      conclude();
   end
endmodule : testbench
